// ---- core/pmw_pkg.sv ----
// Purpose: constants and types for the power management and wake block
// Assumes: 250 MHz core clock, 32-bit Avalon-MM register bus
// Notes: byte offsets of the register map
package pmw_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int ED_PERSIST_NS = 100;
   localparam int ED_PERSIST_CYC = (ED_PERSIST_NS * CLK_MHZ) / 1000;
   localparam int REFRESH_PERIOD_MS = 20;
   localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_MS * CLK_MHZ * 1000;
   localparam int REFRESH_LEN_US = 200;
   localparam int REFRESH_LEN_CYC = REFRESH_LEN_US * CLK_MHZ;
   localparam int TX_WAKE_US = 30;
   localparam int TX_WAKE_CYC = TX_WAKE_US * CLK_MHZ;
   localparam int LINK_PULSE_MS = 16;
   localparam int LINK_PULSE_CYC = LINK_PULSE_MS * CLK_MHZ * 1000;
   localparam int RX_STOP_CYC = 9;
   localparam int SYNC_BYTES = 6;
   localparam int ADDR_COPIES = 16;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_PWR_CTRL = 8'h00;
   localparam logic [7:0] OFS_EEE_CTRL = 8'h04;
   localparam logic [7:0] OFS_ED_TIMEOUT = 8'h08;
   localparam logic [7:0] OFS_WAKE_DUR = 8'h0C;
   localparam logic [7:0] OFS_WAKE_CTRL = 8'h10;
   localparam logic [7:0] OFS_WAKE_STS = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_NODE_LO = 8'h1C;
   localparam logic [7:0] OFS_NODE_HI = 8'h20;
   localparam logic [7:0] OFS_STRAP = 8'h24;
   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int MODE_LSB = 3;
   localparam int WK_ROUTE_BIT = 3;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_ED = 2'h1;
   localparam logic [1:0] MODE_SOFT_DEF = 2'h2;
   localparam logic [31:0] RST_ED_TIMEOUT = 32'h0000_1000;
   localparam logic [31:0] RST_WAKE_DUR = 32'h0000_0100;
   localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
   // ----------------------------------------------------------------
   // global power state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PMW_NORMAL = 2'b00,
      PMW_ED_HIGH = 2'b01,
      PMW_ED_LOW = 2'b10,
      PMW_SOFT_PD = 2'b11
   } pmw_state_t;
endpackage : pmw_pkg

// ---- core/pmw_top.sv ----
// Purpose: global/per-port power modes, EEE low-power idle, wake events
// Assumes: cable energy and link pins are asynchronous; MAC/PHY code
//    indications and receive bytes are on CLK_I
// Notes: registers reached over Avalon-MM with waitrequest
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module pmw_top #(
   parameter int PORTS = 3,
   parameter int EEE_PORTS = 2,
   parameter int TMR_W = 24,
   parameter logic [1:0] MODE_SOFT = pmw_pkg::MODE_SOFT_DEF,
   parameter int REFRESH_PERIOD = pmw_pkg::REFRESH_PERIOD_CYC,
   parameter int REFRESH_LEN = pmw_pkg::REFRESH_LEN_CYC,
   parameter int LINK_PULSE_PERIOD = pmw_pkg::LINK_PULSE_CYC
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // avalon-mm slave
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // cable side, asynchronous
   input wire logic [PORTS-1:0] ENERGY_I,
   input wire logic [PORTS-1:0] LINK_UP_I,
   input wire logic [7:0] STRAP_I,
   // receive byte streams per port
   input wire logic [PORTS*8-1:0] RX_DATA_I,
   input wire logic [PORTS-1:0] RX_VALID_I,
   input wire logic [PORTS-1:0] RX_SOF_I,
   // eee mac/phy side
   input wire logic [EEE_PORTS-1:0] AN_EEE_OK_I,
   input wire logic [EEE_PORTS-1:0] MAC_LPI_REQ_I,
   input wire logic [EEE_PORTS-1:0] RX_PCODE_I,
   input wire logic [EEE_PORTS-1:0] RX_OTHER_I,
   output logic [EEE_PORTS-1:0] TX_LPI_O,
   output logic [EEE_PORTS-1:0] TX_REFRESH_O,
   output logic [EEE_PORTS-1:0] RX_LPI_IND_O,
   output logic [EEE_PORTS-1:0] RX_CLK_STOP_O,
   // power controls
   output logic PLL_EN_O,
   output logic MAC_EN_O,
   output logic HOST_IF_EN_O,
   output logic [PORTS-1:0] PHY_EN_O,
   output logic RX_ED_ONLY_O,
   output logic LINK_PULSE_O,
   output logic STRAP_SAMPLE_O,
   // host notification
   output logic HOST_IRQ_OUT_N_O,
   output logic POWER_EVENT_OUT_N_O
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   pmw_pkg::pmw_state_t state_reg;
   pmw_pkg::pmw_state_t state_next;
   logic [1:0] mode_reg;
   logic [PORTS-1:0] port_pd_reg;
   logic [EEE_PORTS-1:0] eee_en_reg;
   logic [TMR_W-1:0] ed_timeout_reg;
   logic [TMR_W-1:0] wake_dur_reg;
   logic [3:0] wake_ctrl_reg;
   logic [2:0] wake_sts_reg;
   logic [47:0] node_addr_reg;
   logic [7:0] strap_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic req;
   logic wr_en;
   logic [31:0] wmask;
   logic soft_exit;
   logic [PORTS-1:0] en_s1, en_s2, en_s3, en_f;
   logic [PORTS-1:0] lk_s1, lk_s2, lk_s3, lk_f, lk_d;
   logic any_energy;
   logic [TMR_W-1:0] ne_cnt_reg;
   logic [7:0] ep_cnt_reg;
   logic [31:0] lp_cnt_reg;
   logic [TMR_W-1:0] wk_cnt_reg;
   logic [PORTS-1:0] magic_hit;
   logic [2:0] wake_evt;
   logic [EEE_PORTS-1:0] eee_act;
   logic [EEE_PORTS-1:0] rx_lpi;

   assign req = AVS_READ_I | AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = req & ~ack_reg;
   assign AVS_READDATA_O = rdata_reg;
   assign wr_en = AVS_WRITE_I & ack_reg;
   assign wmask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
      {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
   assign soft_exit = wr_en && (AVS_ADDRESS_I == pmw_pkg::OFS_PWR_CTRL)
      && (mode_reg == MODE_SOFT) && AVS_BYTEENABLE_I[0]
      && (AVS_WRITEDATA_I[pmw_pkg::MODE_LSB +: 2] != MODE_SOFT);

   function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction : merge

   // ----------------------------------------------------------------
   // bus slave: one wait cycle, answer on second edge
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rdata_reg <= 32'h0000_0000;
      end else if (AVS_READ_I && !ack_reg) begin
         unique case (AVS_ADDRESS_I)
            pmw_pkg::OFS_PWR_CTRL: rdata_reg <= 32'(
               {mode_reg, port_pd_reg} << (pmw_pkg::MODE_LSB - PORTS));
            pmw_pkg::OFS_EEE_CTRL: rdata_reg <= 32'(eee_en_reg);
            pmw_pkg::OFS_ED_TIMEOUT: rdata_reg <= 32'(ed_timeout_reg);
            pmw_pkg::OFS_WAKE_DUR: rdata_reg <= 32'(wake_dur_reg);
            pmw_pkg::OFS_WAKE_CTRL: rdata_reg <= 32'(wake_ctrl_reg);
            pmw_pkg::OFS_WAKE_STS: rdata_reg <= 32'(wake_sts_reg);
            pmw_pkg::OFS_STATUS: rdata_reg <= 32'({rx_lpi, TX_LPI_O,
               eee_act, lk_f, en_f, state_reg});
            pmw_pkg::OFS_NODE_LO: rdata_reg <= node_addr_reg[31:0];
            pmw_pkg::OFS_NODE_HI: rdata_reg <= 32'(node_addr_reg[47:32]);
            pmw_pkg::OFS_STRAP: rdata_reg <= 32'(strap_reg);
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mode_reg <= pmw_pkg::MODE_NORMAL;
         port_pd_reg <= '0;
         eee_en_reg <= '0;
         ed_timeout_reg <= TMR_W'(pmw_pkg::RST_ED_TIMEOUT);
         wake_dur_reg <= TMR_W'(pmw_pkg::RST_WAKE_DUR);
         wake_ctrl_reg <= 4'h0;
         node_addr_reg <= '0;
      end else if (soft_exit) begin
         mode_reg <= pmw_pkg::MODE_NORMAL;
         port_pd_reg <= '0;
         eee_en_reg <= '0;
         ed_timeout_reg <= TMR_W'(pmw_pkg::RST_ED_TIMEOUT);
         wake_dur_reg <= TMR_W'(pmw_pkg::RST_WAKE_DUR);
         wake_ctrl_reg <= 4'h0;
         node_addr_reg <= '0;
      end else if (wr_en) begin
         unique case (AVS_ADDRESS_I)
            pmw_pkg::OFS_PWR_CTRL: begin
               if (AVS_BYTEENABLE_I[0]) begin
                  mode_reg <= AVS_WRITEDATA_I[pmw_pkg::MODE_LSB +: 2];
                  port_pd_reg <= AVS_WRITEDATA_I[PORTS-1:0];
               end
            end
            pmw_pkg::OFS_EEE_CTRL: begin
               if (AVS_BYTEENABLE_I[0]) begin
                  eee_en_reg <= AVS_WRITEDATA_I[EEE_PORTS-1:0];
               end
            end
            pmw_pkg::OFS_ED_TIMEOUT: ed_timeout_reg <= TMR_W'(merge(
               32'(ed_timeout_reg), AVS_WRITEDATA_I, wmask));
            pmw_pkg::OFS_WAKE_DUR: wake_dur_reg <= TMR_W'(merge(
               32'(wake_dur_reg), AVS_WRITEDATA_I, wmask));
            pmw_pkg::OFS_WAKE_CTRL: begin
               if (AVS_BYTEENABLE_I[0]) begin
                  wake_ctrl_reg <= AVS_WRITEDATA_I[3:0];
               end
            end
            pmw_pkg::OFS_NODE_LO: node_addr_reg[31:0] <= merge(
               node_addr_reg[31:0], AVS_WRITEDATA_I, wmask);
            pmw_pkg::OFS_NODE_HI: node_addr_reg[47:32] <= 16'(merge(
               32'(node_addr_reg[47:32]), AVS_WRITEDATA_I, wmask));
            default: ;
         endcase
      end
   end

   // strap capture after release and on soft exit
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         STRAP_SAMPLE_O <= 1'b1;
         strap_reg <= 8'h00;
      end else begin
         STRAP_SAMPLE_O <= soft_exit;
         if (STRAP_SAMPLE_O) begin
            strap_reg <= STRAP_I;
         end
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers, change counts when stages 2 and 3 agree
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         {en_s1, en_s2, en_s3, en_f} <= '0;
         {lk_s1, lk_s2, lk_s3, lk_f, lk_d} <= '0;
      end else begin
         en_s1 <= ENERGY_I;
         en_s2 <= en_s1;
         en_s3 <= en_s2;
         en_f <= (en_s2 & en_s3) | (en_f & (en_s2 | en_s3));
         lk_s1 <= LINK_UP_I;
         lk_s2 <= lk_s1;
         lk_s3 <= lk_s2;
         lk_f <= (lk_s2 & lk_s3) | (lk_f & (lk_s2 | lk_s3));
         lk_d <= lk_f;
      end
   end

   assign any_energy = |(en_f & ~port_pd_reg);

   // ----------------------------------------------------------------
   // global power state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         pmw_pkg::PMW_ED_HIGH: begin
            if (ne_cnt_reg > ed_timeout_reg) begin
               state_next = pmw_pkg::PMW_ED_LOW;
            end
         end
         pmw_pkg::PMW_ED_LOW: begin
            if (ep_cnt_reg > 8'(pmw_pkg::ED_PERSIST_CYC)) begin
               state_next = pmw_pkg::PMW_ED_HIGH;
            end
         end
         default: begin
            if (mode_reg == pmw_pkg::MODE_ED) begin
               state_next = pmw_pkg::PMW_ED_HIGH;
            end
         end
      endcase
      if (mode_reg == pmw_pkg::MODE_NORMAL) begin
         state_next = pmw_pkg::PMW_NORMAL;
      end else if (mode_reg == MODE_SOFT) begin
         state_next = pmw_pkg::PMW_SOFT_PD;
      end else if (mode_reg != pmw_pkg::MODE_ED) begin
         state_next = pmw_pkg::PMW_NORMAL;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_reg <= pmw_pkg::PMW_NORMAL;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ne_cnt_reg <= '0;
         ep_cnt_reg <= 8'h00;
      end else begin
         if (state_reg == pmw_pkg::PMW_ED_HIGH && !any_energy) begin
            if (ne_cnt_reg != '1) begin
               ne_cnt_reg <= ne_cnt_reg + 1'b1;
            end
         end else begin
            ne_cnt_reg <= '0;
         end
         if (state_reg == pmw_pkg::PMW_ED_LOW && any_energy) begin
            if (ep_cnt_reg != 8'hFF) begin
               ep_cnt_reg <= ep_cnt_reg + 8'h01;
            end
         end else begin
            ep_cnt_reg <= 8'h00;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         lp_cnt_reg <= 32'h0000_0000;
         LINK_PULSE_O <= 1'b0;
      end else if (state_reg == pmw_pkg::PMW_ED_LOW) begin
         LINK_PULSE_O <= (lp_cnt_reg == 32'h0000_0000);
         lp_cnt_reg <= (lp_cnt_reg == 32'(LINK_PULSE_PERIOD - 1)) ?
            32'h0000_0000 : lp_cnt_reg + 32'h0000_0001;
      end else begin
         lp_cnt_reg <= 32'h0000_0000;
         LINK_PULSE_O <= 1'b0;
      end
   end

   // only management stays in soft power-down
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PLL_EN_O <= 1'b1;
         MAC_EN_O <= 1'b1;
         HOST_IF_EN_O <= 1'b1;
         PHY_EN_O <= '1;
         RX_ED_ONLY_O <= 1'b0;
      end else begin
         PLL_EN_O <= (state_reg == pmw_pkg::PMW_NORMAL);
         MAC_EN_O <= (state_reg == pmw_pkg::PMW_NORMAL);
         HOST_IF_EN_O <= (state_reg == pmw_pkg::PMW_NORMAL);
         PHY_EN_O <= {PORTS{state_reg == pmw_pkg::PMW_NORMAL}}
            & ~port_pd_reg;
         RX_ED_ONLY_O <= (state_reg == pmw_pkg::PMW_ED_HIGH) ||
            (state_reg == pmw_pkg::PMW_ED_LOW);
      end
   end

   // ----------------------------------------------------------------
   // eee low-power idle, phy ports only
   // ----------------------------------------------------------------
   // generated for the first two ports only
   for (genvar p = 0; p < EEE_PORTS; p++) begin : g_eee
      logic [31:0] rf_cnt_reg;
      logic [3:0] rx_cnt_reg;
      assign eee_act[p] = eee_en_reg[p] & AN_EEE_OK_I[p];
      always_ff @(posedge CLK_I or negedge RST_N_I) begin
         if (!RST_N_I) begin
            TX_LPI_O[p] <= 1'b0;
            TX_REFRESH_O[p] <= 1'b0;
            rf_cnt_reg <= 32'h0000_0000;
         end else begin
            // exit next cycle, well under 30us
            TX_LPI_O[p] <= eee_act[p] & MAC_LPI_REQ_I[p];
            if (TX_LPI_O[p] && MAC_LPI_REQ_I[p]) begin
               TX_REFRESH_O[p] <= (rf_cnt_reg < 32'(REFRESH_LEN));
               rf_cnt_reg <= (rf_cnt_reg == 32'(REFRESH_PERIOD - 1)) ?
                  32'h0000_0000 : rf_cnt_reg + 32'h0000_0001;
            end else begin
               TX_REFRESH_O[p] <= 1'b0;
               rf_cnt_reg <= 32'h0000_0000;
            end
         end
      end
      always_ff @(posedge CLK_I or negedge RST_N_I) begin
         if (!RST_N_I) begin
            rx_lpi[p] <= 1'b0;
            rx_cnt_reg <= 4'h0;
            RX_CLK_STOP_O[p] <= 1'b0;
         end else begin
            if (!eee_act[p] || RX_OTHER_I[p]) begin
               rx_lpi[p] <= 1'b0;
            end else if (RX_PCODE_I[p]) begin
               rx_lpi[p] <= 1'b1;
            end
            if (rx_lpi[p] && !RX_OTHER_I[p] && eee_act[p]) begin
               if (rx_cnt_reg != 4'hF) begin
                  rx_cnt_reg <= rx_cnt_reg + 4'h1;
               end
            end else begin
               rx_cnt_reg <= 4'h0;
            end
            RX_CLK_STOP_O[p] <= rx_lpi[p] && !RX_OTHER_I[p] &&
               (rx_cnt_reg >= 4'(pmw_pkg::RX_STOP_CYC));
         end
      end
   end
   assign RX_LPI_IND_O = rx_lpi;

   // ----------------------------------------------------------------
   // wake frame detectors, one per port
   // ----------------------------------------------------------------
   for (genvar p = 0; p < PORTS; p++) begin : g_wake
      logic [2:0] ff_cnt_reg;
      logic [6:0] mt_cnt_reg;
      logic [7:0] rx_b;
      logic [7:0] exp_b;
      assign rx_b = RX_DATA_I[p*8 +: 8];
      // address sent most significant byte first
      assign exp_b = node_addr_reg[8*(5 - (mt_cnt_reg % 7'd6)) +: 8];
      always_ff @(posedge CLK_I or negedge RST_N_I) begin
         if (!RST_N_I) begin
            ff_cnt_reg <= 3'h0;
            mt_cnt_reg <= 7'h00;
            magic_hit[p] <= 1'b0;
         end else begin
            magic_hit[p] <= 1'b0;
            if (RX_SOF_I[p]) begin
               ff_cnt_reg <= 3'h0;
               mt_cnt_reg <= 7'h00;
            end else if (RX_VALID_I[p]) begin
               if (ff_cnt_reg == 3'(pmw_pkg::SYNC_BYTES) &&
                  rx_b == exp_b) begin
                  if (mt_cnt_reg ==
                     7'(pmw_pkg::ADDR_COPIES * 6 - 1)) begin
                     magic_hit[p] <= 1'b1;
                     ff_cnt_reg <= 3'h0;
                     mt_cnt_reg <= 7'h00;
                  end else begin
                     mt_cnt_reg <= mt_cnt_reg + 7'h01;
                  end
               end else if (rx_b == pmw_pkg::BYTE_ALL_ONES) begin
                  mt_cnt_reg <= 7'h00;
                  if (ff_cnt_reg != 3'(pmw_pkg::SYNC_BYTES)) begin
                     ff_cnt_reg <= ff_cnt_reg + 3'h1;
                  end
               end else begin
                  ff_cnt_reg <= 3'h0;
                  mt_cnt_reg <= 7'h00;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // wake events and host notification
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wk_cnt_reg <= '0;
      end else if (any_energy) begin
         if (wk_cnt_reg != '1) begin
            wk_cnt_reg <= wk_cnt_reg + 1'b1;
         end
      end else begin
         wk_cnt_reg <= '0;
      end
   end

   assign wake_evt = {|magic_hit, |(lk_f & ~lk_d),
      any_energy && (wk_cnt_reg == wake_dur_reg)} & wake_ctrl_reg[2:0];

   // sticky status, write one to clear, set wins
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wake_sts_reg <= 3'h0;
      end else begin
         if (soft_exit) begin
            wake_sts_reg <= wake_evt;
         end else if (wr_en && AVS_BYTEENABLE_I[0] &&
            AVS_ADDRESS_I == pmw_pkg::OFS_WAKE_STS) begin
            wake_sts_reg <= (wake_sts_reg & ~AVS_WRITEDATA_I[2:0])
               | wake_evt;
         end else begin
            wake_sts_reg <= wake_sts_reg | wake_evt;
         end
      end
   end

   // route to interrupt or power event
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         HOST_IRQ_OUT_N_O <= 1'b1;
         POWER_EVENT_OUT_N_O <= 1'b1;
      end else begin
         HOST_IRQ_OUT_N_O <= ~((|wake_sts_reg) &
            ~wake_ctrl_reg[pmw_pkg::WK_ROUTE_BIT]);
         POWER_EVENT_OUT_N_O <= ~((|wake_sts_reg) &
            wake_ctrl_reg[pmw_pkg::WK_ROUTE_BIT]);
      end
   end
endmodule : pmw_top

// ---- testbench/pmw_chk.sv ----
// Purpose: port assertions. Assumes: two eee ports. Notes: bind at foot
`timescale 1ns/100ps
module pmw_chk (
   input wire logic CLK_I, RST_N_I, PLL_EN_O, MAC_EN_O, HOST_IF_EN_O,
   input wire logic RX_ED_ONLY_O, HOST_IRQ_OUT_N_O, POWER_EVENT_OUT_N_O,
   input wire logic [1:0] AN_EEE_OK_I, MAC_LPI_REQ_I, RX_OTHER_I,
   input wire logic [1:0] TX_LPI_O, TX_REFRESH_O, RX_LPI_IND_O,
   input wire logic [1:0] RX_CLK_STOP_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_lpi_on;
      !TX_LPI_O[0] ##1 TX_LPI_O[0];
   endsequence
   a_en_group: assert property (
      MAC_EN_O == PLL_EN_O && HOST_IF_EN_O == PLL_EN_O) else $error("en");
   a_ed_no_pll: assert property (RX_ED_ONLY_O |-> !PLL_EN_O)
      else $error("pll on in ed");
   a_eee_needs_an: assert property (!AN_EEE_OK_I[0] |=> !TX_LPI_O[0])
      else $error("lpi without an");
   a_lpi_follows: assert property (s_lpi_on |-> $past(MAC_LPI_REQ_I[0]))
      else $error("lpi without request");
   a_refresh_lpi: assert property (TX_REFRESH_O[0] |-> $past(TX_LPI_O[0]))
      else $error("refresh outside lpi");
   a_other_exit: assert property (RX_OTHER_I[0] |=> !RX_LPI_IND_O[0])
      else $error("rx lpi kept");
   a_stop_nine: assert property (
      $rose(RX_CLK_STOP_O[0]) |-> $past(RX_LPI_IND_O[0], 9)) else $error("stop");
   a_one_notify: assert property (HOST_IRQ_OUT_N_O || POWER_EVENT_OUT_N_O)
      else $error("both notify pins");
endmodule : pmw_chk
bind pmw_top pmw_chk u_chk (.CLK_I, .RST_N_I, .PLL_EN_O, .MAC_EN_O,
   .HOST_IF_EN_O, .RX_ED_ONLY_O, .HOST_IRQ_OUT_N_O, .POWER_EVENT_OUT_N_O,
   .AN_EEE_OK_I, .MAC_LPI_REQ_I, .RX_OTHER_I, .TX_LPI_O, .TX_REFRESH_O,
   .RX_LPI_IND_O, .RX_CLK_STOP_O);

// ---- testbench/pmw_link_model.sv ----
// Purpose: cable partner. Assumes: levels. Notes: link on port 0 only
`timescale 1ns/100ps
module pmw_link_model (
   input wire logic clk_i,
   input wire logic energy_cmd_i,
   input wire logic link_cmd_i,
   output logic [2:0] energy_o = 3'h0,
   output logic [2:0] link_o = 3'h0
);
   always @(posedge clk_i) begin
      energy_o <= {3{energy_cmd_i}};
      link_o <= {2'h0, link_cmd_i};
   end
endmodule : pmw_link_model

// ---- testbench/pmw_tb_top.sv ----
// Purpose: pmw bench. Assumes: short refresh. Notes: task per scenario
`timescale 1ns/100ps
module pmw_tb_top;
   logic clk = 1'h0, rst_n = 1'h0, rd = 1'h0, wr = 1'h0;
   logic en_c = 1'h0, lk_c = 1'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [1:0] ok = 2'h0, req = 2'h0, pc = 2'h0, oth = 2'h0;
   logic [31:0] rdat;
   logic [31:0] rv;
   logic [7:0] stp = 8'h5A;
   logic [23:0] rxd = 24'h00_0000;
   logic [2:0] rxv = 3'h0, rxs = 3'h0, phy;
   logic lp;
   logic [2:0] eng, lnk;
   logic [1:0] tlpi, rlpi, cstp;
   logic wq, pll, edo, irq_n, power_event_out_n;
   int error_cnt = 0;
   int checks_done = 0;
   always #2 clk = ~clk;
   pmw_top #(.REFRESH_PERIOD(200), .REFRESH_LEN(20),
      .LINK_PULSE_PERIOD(50)) uut (.CLK_I(clk), .RST_N_I(rst_n),
      .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF),
      .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq),
      .ENERGY_I(eng), .LINK_UP_I(lnk), .STRAP_I(stp),
      .RX_DATA_I(rxd), .RX_VALID_I(rxv), .RX_SOF_I(rxs),
      .AN_EEE_OK_I(ok), .MAC_LPI_REQ_I(req), .RX_PCODE_I(pc),
      .RX_OTHER_I(oth), .TX_LPI_O(tlpi), .TX_REFRESH_O(),
      .RX_LPI_IND_O(rlpi), .RX_CLK_STOP_O(cstp), .PLL_EN_O(pll),
      .MAC_EN_O(), .HOST_IF_EN_O(), .PHY_EN_O(phy), .RX_ED_ONLY_O(edo),
      .LINK_PULSE_O(lp), .STRAP_SAMPLE_O(),
      .HOST_IRQ_OUT_N_O(irq_n), .POWER_EVENT_OUT_N_O(power_event_out_n));
   pmw_link_model lm (.clk_i(clk), .energy_cmd_i(en_c),
      .link_cmd_i(lk_c), .energy_o(eng), .link_o(lnk));
   task chk(input logic [31:0] a, input logic [31:0] e);
      checks_done++;
      if (a !== e) begin
         error_cnt++;
         $display("BAD %0t %h %h", $time, a, e);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk); while (wq !== 1'h0);
      rv = rdat;
      wr <= 1'h0;
      rd <= 1'h0;
      @(posedge clk);
   endtask : bus
   task t_ed;
      logic [31:0] n;
      ok <= 2'h3;
      bus(1'h1, 8'h00, 32'h0000_0002);
      repeat (2) @(posedge clk);
      chk(phy, 32'h0000_0005);
      bus(1'h1, 8'h08, 32'h0000_0008);
      bus(1'h1, 8'h00, 32'h0000_0008);
      repeat (3) @(posedge clk);
      chk({pll, edo}, 2'h1);
      repeat (40) @(posedge clk);
      n = 32'h0000_0000;
      repeat (50) begin
         @(posedge clk);
         n = n + lp;
      end
      chk(n, 32'h0000_0001);
      bus(1'h0, 8'h18, 0);
      chk(rv & 32'h3, 32'h2);
      en_c <= 1'h1;
      repeat (50) @(posedge clk);
      bus(1'h0, 8'h18, 0);
      chk(rv & 32'h3, 32'h1);
      bus(1'h1, 8'h00, 32'h0000_0010);
      repeat (3) @(posedge clk);
      chk({pll, edo}, 2'h0);
      stp <= 8'hA5;
      bus(1'h1, 8'h00, 0);
      bus(1'h0, 8'h08, 0);
      chk(rv, 32'h0000_1000);
      bus(1'h0, 8'h24, 0);
      chk(rv, 32'h0000_00A5);
   endtask : t_ed
   task t_eee;
      ok <= 2'h3;
      req <= 2'h3;
      repeat (4) @(posedge clk);
      chk(tlpi, 2'h0);
      bus(1'h1, 8'h04, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk(tlpi, 2'h1);
      repeat (220) @(posedge clk);
      req <= 2'h0;
      pc <= 2'h1;
      @(posedge clk);
      pc <= 2'h0;
      repeat (14) @(posedge clk);
      chk({tlpi, rlpi, cstp}, 6'h05);
      oth <= 2'h1;
      @(posedge clk);
      oth <= 2'h0;
      repeat (2) @(posedge clk);
      chk(rlpi, 2'h0);
   endtask : t_eee
   task t_wake;
      bus(1'h1, 8'h10, 32'h0000_0002);
      lk_c <= 1'h1;
      repeat (10) @(posedge clk);
      chk({irq_n, power_event_out_n}, 2'h1);
      bus(1'h1, 8'h14, 32'h0000_0007);
      repeat (3) @(posedge clk);
      chk({irq_n, power_event_out_n}, 2'h3);
      bus(1'h1, 8'h10, 32'h0000_000A);
      lk_c <= 1'h0;
      repeat (8) @(posedge clk);
      lk_c <= 1'h1;
      repeat (10) @(posedge clk);
      chk({irq_n, power_event_out_n}, 2'h2);
   endtask : t_wake
   task t_frame;
      logic [47:0] na;
      na = 48'h0A1B_2C3D_4E5F;
      bus(1'h1, 8'h20, 32'h0000_0A1B);
      bus(1'h1, 8'h1C, 32'h2C3D_4E5F);
      bus(1'h1, 8'h10, 32'h0000_0004);
      bus(1'h1, 8'h14, 32'h0000_0007);
      rxs <= 3'h2;
      @(posedge clk);
      rxs <= 3'h0;
      rxv <= 3'h2;
      rxd <= 24'h00_FF00;
      repeat (6) @(posedge clk);
      for (int i = 0; i < 96; i++) begin
         rxd <= {8'h00, na[8*(5 - i % 6) +: 8], 8'h00};
         @(posedge clk);
      end
      rxv <= 3'h0;
      repeat (4) @(posedge clk);
      chk({irq_n, power_event_out_n}, 2'h1);
   endtask : t_frame
   task print_verdict;
      if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      bus(1'h0, 8'h00, 0);
      chk(rv, 32'h0000_0000);
      t_ed;
      t_eee;
      t_wake;
      t_frame;
      print_verdict;
   end
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      print_verdict;
   end
endmodule : pmw_tb_top
